// ---- sid_cfg.svh ----
// Constants for the subtract instruction datapath
`ifndef SID_CFG_SVH
`define SID_CFG_SVH

// Subtract-from-file opcode pattern, bits 13:8 without d
`define SID_SUBF_OP      6'h02
`define SID_SUBF_OP_HI   13
`define SID_SUBF_OP_LO   8
`define SID_SUBF_D_BIT   7
// Subtract-from-literal: bits 13:9 are 11110, bit 8 don't care
`define SID_SUBL_OP      5'h1e
`define SID_SUBL_OP_HI   13
`define SID_SUBL_OP_LO   9
// W and status flag reset values
`define SID_W_RST        8'h00
`define SID_FLAG_RST     1'b0

`endif

// ---- sid_pkg.sv ----
// Types for the subtract instruction datapath
`default_nettype none

package sid_pkg;
    typedef enum logic [1:0] {
        SID_OP_NONE,
        SID_OP_SUBL,
        SID_OP_SUBF
    } sid_op_t;

    typedef struct packed {
        logic [7:0] w;
        logic       carry;
        logic       digit_carry;
        logic       zero;
        logic       file_we;
        logic [6:0] file_addr;
        logic [7:0] file_wdata;
        logic       done;
    } sid_state_t;
endpackage : sid_pkg

`default_nettype wire

// ---- sid_core.sv ----
// Subtract instruction datapath: decode, subtract, flags, write-back
//
// How it works
// - Literal form computes literal minus W, result into W.
// - Pattern 00 0010 dfff ffff decodes as file minus W.
// - File form: d=0 writes W, d=1 writes file register back.
// - No borrow leaves the carry flag set to one.
`timescale 1ns/100ps
`default_nettype none
`include "sid_cfg.svh"

module sid_core (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Instruction from decode pipeline, file register read data
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    input  wire logic [7:0]  file_rdata,
    // Register file write-back
    output logic             file_we,
    output logic [6:0]       file_addr,
    output logic [7:0]       file_wdata,
    // Core state
    output logic [7:0]       w,
    output logic             carry,
    output logic             digit_carry,
    output logic             zero,
    output logic             done
);
    import sid_pkg::*;

    // ****************************************
    // State
    // ****************************************
    sid_state_t state;
    sid_state_t next_state;
    sid_op_t    op;
    logic       is_subl;
    logic       is_subf;
    logic       to_file;
    logic [7:0] literal;
    logic [6:0] file_sel;
    logic [7:0] minuend;
    logic [7:0] diff;
    logic       no_borrow;
    logic       low_no_borrow;
    logic       result_zero;

    // ****************************************
    // Decode
    // ****************************************
    // Instruction fields, only meaningful for the form that matched
    assign literal  = instr[7:0];
    assign file_sel = instr[6:0];
    assign to_file  = instr[`SID_SUBF_D_BIT];

    // Literal form ignores bit 8, so its pattern is one bit shorter
    sid_match #(
        .WIDTH   (5),
        .PATTERN (`SID_SUBL_OP)
    ) u_match_subl (
        .valid (instr_valid),
        .field (instr[`SID_SUBL_OP_HI:`SID_SUBL_OP_LO]),
        .hit   (is_subl)
    );

    sid_match #(
        .WIDTH   (6),
        .PATTERN (`SID_SUBF_OP)
    ) u_match_subf (
        .valid (instr_valid),
        .field (instr[`SID_SUBF_OP_HI:`SID_SUBF_OP_LO]),
        .hit   (is_subf)
    );

    // Patterns are disjoint; literal is tested first regardless
    always_comb begin
        op = SID_OP_NONE;
        if (is_subl) begin
            op = SID_OP_SUBL;
        end else if (is_subf) begin
            op = SID_OP_SUBF;
        end
    end

    // ****************************************
    // Operands and subtractors
    // ****************************************
    // Literal for one form, addressed file register for the other
    assign minuend = (op == SID_OP_SUBL) ? literal : file_rdata;

    // Byte result and carry
    sid_sub #(
        .WIDTH(8)
    ) u_sub_byte (
        .minuend    (minuend),
        .subtrahend (state.w),
        .diff       (diff),
        .no_borrow  (no_borrow)
    );

    // Low nibble only feeds digit_carry, its difference is dropped
    sid_sub #(
        .WIDTH(4)
    ) u_sub_nibble (
        .minuend    (minuend[3:0]),
        .subtrahend (state.w[3:0]),
        .diff       (),
        .no_borrow  (low_no_borrow)
    );

    assign result_zero = (diff == 8'h00);

    // ****************************************
    // Subtract and flags
    // ****************************************
    always_comb begin
        next_state         = state;
        next_state.file_we = 1'b0;
        next_state.done    = 1'b0;
        case (op)
            SID_OP_SUBL: begin
                next_state.w = diff;
            end
            SID_OP_SUBF: begin
                if (to_file) begin
                    next_state.file_we    = 1'b1;
                    next_state.file_addr  = file_sel;
                    next_state.file_wdata = diff;
                end else begin
                    next_state.w = diff;
                end
            end
            default: begin
            end
        endcase
        if (op != SID_OP_NONE) begin
            // Single cycle: flags land with the result
            next_state.carry       = no_borrow;
            next_state.digit_carry = low_no_borrow;
            next_state.zero        = result_zero;
            next_state.done        = 1'b1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state             <= '0;
            state.w           <= `SID_W_RST;
            state.carry       <= `SID_FLAG_RST;
            state.digit_carry <= `SID_FLAG_RST;
            state.zero        <= `SID_FLAG_RST;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign file_we     = state.file_we;
    assign file_addr   = state.file_addr;
    assign file_wdata  = state.file_wdata;
    assign w           = state.w;
    assign carry       = state.carry;
    assign digit_carry = state.digit_carry;
    assign zero        = state.zero;
    assign done        = state.done;
endmodule : sid_core

// ****************************************
// Opcode matcher
// ****************************************
// Compares the opcode field of a valid word against one fixed pattern
module sid_match #(
    parameter int               WIDTH   = 6,
    parameter logic [WIDTH-1:0] PATTERN = '0
) (
    // Word under decode
    input  wire logic             valid,
    input  wire logic [WIDTH-1:0] field,
    // Match
    output logic                  hit
);
    assign hit = valid && (field == PATTERN);
endmodule : sid_match

// ****************************************
// Subtractor
// ****************************************
// Minuend minus subtrahend with an inverted borrow out, so one
// cell serves both the byte result and the low nibble
module sid_sub #(
    parameter int WIDTH = 8
) (
    // Operands
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    // Result
    output logic      [WIDTH-1:0] diff,
    output logic                  no_borrow
);
    logic [WIDTH:0] wide;

    // One extra bit catches the borrow
    always_comb begin
        wide      = {1'b0, minuend} - {1'b0, subtrahend};
        diff      = wide[WIDTH-1:0];
        no_borrow = ~wide[WIDTH];
    end
endmodule : sid_sub

`default_nettype wire

// ---- sid_core_asserts.sv ----
// Port assertions for the subtract datapath
`timescale 1ns/100ps
`default_nettype none
module sid_asserts(input wire logic sys_clk,rst,instr_valid,input wire logic [13:0] instr,
input wire logic [7:0] file_rdata,file_wdata,w,input wire logic [6:0] file_addr,
input wire logic file_we,carry,digit_carry,zero,done);
logic [8:0] d;
logic [4:0] n;
logic [6:0] a;
wire [7:0] s=instr[13]?instr[7:0]:file_rdata;
wire l=instr_valid&&instr[13:9]==5'h1e, f=instr_valid&&instr[13:8]==6'h02;
always_ff @(posedge sys_clk) begin
    d <= {1'b0,s}-{1'b0,w};
    n <= {1'b0,s[3:0]}-{1'b0,w[3:0]};
    a <= instr[6:0];
end
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
sequence s_wb; file_we&&file_addr==a&&file_wdata==d[7:0]; endsequence
AST_L: assert property (l|=>w==d[7:0]) else $error("bad w");
AST_F: assert property (f|=>done) else $error("no done");
AST_D: assert property (f&&instr[7]|=>s_wb and $stable(w)) else $error("bad wb");
AST_C: assert property ((l||f)|=>carry!=d[8]) else $error("bad carry");
AST_Z: assert property ((l||f)|=>digit_carry!=n[4]&&zero==(d[7:0]==8'h00)) else $error("bad flag");
AST_W0: assert property (f&&!instr[7]|=>w==d[7:0]&&!file_we) else $error("bad w write");
AST_LF: assert property (l|=>done&&!file_we) else $error("literal wrote file");
AST_N: assert property (!(l||f)|=>!done&&!file_we) else $error("bad idle");
endmodule : sid_asserts
bind sid_core sid_asserts u_chk(.sys_clk(sys_clk),.rst(rst),.instr_valid(instr_valid),
    .instr(instr),.file_rdata(file_rdata),.file_wdata(file_wdata),.w(w),
    .file_addr(file_addr),.file_we(file_we),.carry(carry),.digit_carry(digit_carry),
    .zero(zero),.done(done));
`default_nettype wire

// ---- sid_rf.sv ----
// File register model, forwards a write in flight
`timescale 1ns/100ps
`default_nettype none
module sid_rf(input wire logic clk,we,input wire logic [6:0] ra,wa,input wire logic [7:0] wd,
output logic [7:0] rd);
logic [7:0] m[128];
initial for (int i=0;i<128;i++) m[i]=8'(i*37);
assign rd=we&&wa==ra?wd:m[ra];
always @(posedge clk) if (we) m[wa]<=wd;
endmodule : sid_rf
`default_nettype wire

// ---- subtract_instr_datapath_test.sv ----
// Self-checking bench for the subtract datapath
`timescale 1ns/100ps
`default_nettype none
module subtract_instr_datapath_test;
logic sys_clk=0,rst=1,instr_valid=0,file_we,carry,digit_carry,zero,done,b;
logic [13:0] instr=0,i;
logic [7:0] file_rdata,file_wdata,w,mw=0,m[128];
logic [6:0] file_addr;
logic [8:0] d;
logic [4:0] n;
logic [26:0] q[$],x,o;
logic [27:0] r;
int err_count=0,check_count=0,seed=32'ha1163bfd;
always #25 sys_clk=~sys_clk;
initial for (int k=0;k<128;k++) m[k]=8'(k*37);
sid_core DUT(.sys_clk(sys_clk),.rst(rst),.instr_valid(instr_valid),.instr(instr),
    .file_rdata(file_rdata),.file_we(file_we),.file_addr(file_addr),.file_wdata(file_wdata),
    .w(w),.carry(carry),.digit_carry(digit_carry),.zero(zero),.done(done));
sid_rf u_rf(.clk(sys_clk),.we(file_we),.ra(instr[6:0]),.wa(file_addr),.wd(file_wdata),
    .rd(file_rdata));
task issue(input logic [13:0] v);
    @(negedge sys_clk);
    instr=v;
    instr_valid=1;
    if (v[13:9]==5'h1e||v[13:8]==6'h02) begin
        i[7:0]=v[13]?v[7:0]:m[v[6:0]];
        d={1'b0,i[7:0]}-{1'b0,mw};
        n={1'b0,i[3:0]}-{1'b0,mw[3:0]};
        b=!v[13]&&v[7];
        if (b) m[v[6:0]]=d[7:0];
        else mw=d[7:0];
        q.push_back({mw,!d[8],!n[4],d[7:0]==8'h00,b,b?{v[6:0],d[7:0]}:15'h0});
    end
endtask : issue
always @(negedge sys_clk) if (done===1'b1) begin
    x=q.size()?q.pop_front():'x;
    o={w,carry,digit_carry,zero,file_we,file_we?{file_addr,file_wdata}:15'h0};
    check_count++;
    if (o!==x) begin
        err_count++;
        $display("unexpected result: expected %h seen %h",x,o);
    end
end
task stop_test;
    $display("mismatches %0d checks %0d",err_count,check_count);
    if (err_count==0&&check_count>0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask : stop_test
initial begin
    repeat (12) @(negedge sys_clk);
    rst=0;
    issue(14'h3c01);
    issue(14'h3c02);
    issue(14'h3d01);
    issue(14'h02a0);
    issue(14'h0220);
    issue(14'h0320);
    @(negedge sys_clk);
    instr_valid=0;
    rst=1;
    repeat (2) @(negedge sys_clk);
    r={w,carry,digit_carry,zero,file_we,done,file_addr,file_wdata};
    check_count++;
    if (r!==28'h0) begin
        err_count++;
        $display("unexpected reset state: expected %h seen %h",28'h0,r);
    end
    rst=0;
    mw=8'h00;
    $display("directed test done");
    repeat (300) begin
        i=14'($random(seed));
        issue(i[13]?{5'h1e,i[8:0]}:i[12]?{6'h02,i[7:0]}:i);
    end
    @(negedge sys_clk);
    instr_valid=0;
    repeat (3) @(negedge sys_clk);
    if (q.size()!=0) begin
        err_count++;
        $display("unexpected pending results: expected %0d seen %0d",0,q.size());
    end
    $display("random test done");
    stop_test();
end
initial begin
    #100000;
    err_count++;
    stop_test();
end
endmodule : subtract_instr_datapath_test
`default_nettype wire
